// File: shared/pcef_consts.vh
// Register addresses, field positions and status bit positions of the counter control block
`ifndef PCEF_CONSTS_VH
`define PCEF_CONSTS_VH

// Register addresses in model-specific register space
`define PCEF_ADDR_EVTSEL0 32'h0000_0186
`define PCEF_ADDR_GPCTR0 32'h0000_00c1
`define PCEF_ADDR_FIXCTR0 32'h0000_0309
`define PCEF_ADDR_FIXCTL 32'h0000_0380
`define PCEF_ADDR_GSTAT 32'h0000_0381
`define PCEF_ADDR_GCTRL 32'h0000_0382
`define PCEF_ADDR_GOVF 32'h0000_0383
`define PCEF_ADDR_DBGCTL 32'h0000_0384

// Fixed counters and their 4-bit control blocks
`define PCEF_NFIX 3
`define PCEF_FIX_BLK 4
`define PCEF_FIX_OS 0
`define PCEF_FIX_USR 1
`define PCEF_FIX_ANY 2
`define PCEF_FIX_PMI 3
`define PCEF_FIXCTL_W 12

// Event select fields
`define PCEF_SEL_W 32
`define PCEF_SEL_USR 16
`define PCEF_SEL_OS 17
`define PCEF_SEL_INT 20
`define PCEF_SEL_ANY 21
`define PCEF_SEL_EN 22

// Global control / status / clear bit positions
`define PCEF_FIX_BASE 32
`define PCEF_ST_TRACE 55
`define PCEF_ST_BRANCH_RECORD_FROZEN 58
`define PCEF_ST_COUNTERS_FROZEN 59
`define PCEF_ST_ENCL 60

// Debug control fields
`define PCEF_DBG_W 16
`define PCEF_DBG_LBR 0
`define PCEF_DBG_FRZ_LBR 11
`define PCEF_DBG_FRZ_CTR 12

`endif

// File: logic/pcef_counter.v
// One event counter with privilege filtering and core-wide source selection
`timescale 1ns/10ps
module pcef_counter #(
    parameter W = 48 // Counter width
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire cnt_en_i,
    input wire usr_en_i,
    input wire os_en_i,
    input wire any_i,
    input wire own_evt_i,
    input wire sib_evt_i,
    input wire own_user_i,
    input wire sib_user_i,
    input wire wr_i,
    input wire [W-1:0] wdata_i,
    output reg [W-1:0] count_o,
    output wire ovf_o
);
    // Privilege match for one logical processor
    function priv_ok;
        input user;
        input usr_en;
        input os_en;
        begin
            priv_ok = user ? usr_en : os_en;
        end
    endfunction

    wire own_hit; // Own thread qualified event
    wire sib_hit; // Sibling thread qualified event
    wire [1:0] inc; // Increment this cycle
    wire [W:0] sum; // Count plus increment, with carry

    // Own thread always counts; sibling only in core-wide mode
    assign own_hit = own_evt_i & priv_ok(own_user_i, usr_en_i, os_en_i);
    assign sib_hit = any_i & sib_evt_i & priv_ok(sib_user_i, usr_en_i, os_en_i);
    assign inc = cnt_en_i ? ({1'b0, own_hit} + {1'b0, sib_hit}) : 2'h0;
    assign sum = {1'b0, count_o} + {{(W-1){1'b0}}, inc};
    // Wrap past all ones is an overflow, not on a software write
    assign ovf_o = ce_i & ~wr_i & sum[W];

    // Counter register, software write has priority over counting
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_o <= {W{1'b0}};
        end else if (ce_i) begin
            if (wr_i) begin
                count_o <= wdata_i;
            end else begin
                count_o <= sum[W-1:0];
            end
        end
    end
endmodule // pcef_counter

// File: logic/pcef_status.v
// Sticky global status register with set-over-clear priority
`timescale 1ns/10ps
module pcef_status #(
    parameter [63:0] IMPL = 64'h0 // Implemented bit mask
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire [63:0] set_i,
    input wire [63:0] clr_i,
    output reg [63:0] status_o
);
    wire [63:0] next_status; // Next status value

    // Hardware set beats a simultaneous software clear
    assign next_status = ((status_o & ~clr_i) | set_i) & IMPL;

    // Status flops
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_o <= 64'h0;
        end else if (ce_i) begin
            status_o <= next_status;
        end
    end
endmodule // pcef_status

// File: logic/pcef_top.v
// Event counter enables, freeze indicators and global status of one logical processor
//
// Notes on behaviour
// - Core-wide select bit counts all sibling threads
// - Bit clear: count own thread's events only
// - Event selects consecutive from address 186h
// - Fixed counters from 309h, 4-bit control each
// - Fixed core-wide bit at 2+4N
// - Fixed core-wide bit clear: own thread only
// - Global registers: bit per counter, three fixed
// - Freeze branch records on interrupting overflow, bit58
// - Capture branches: record enable and not frozen
// - Freeze counters on interrupting overflow, bit59
// - General counter: select, global enable, unfrozen
// - Fixed counter: control, global enable, unfrozen
// - Counters-frozen bit not writable through status
// - Trace buffer full interrupt sets bit55
// - Enclave contribution to counts sets bit60
// - Bits 55, 60 only with capability
// - No legacy freeze; debug bits drive indicators
// - Fixed control fourth bit requests overflow interrupt
// - Overflow sets status bits 0,1,32-34
// - Overflow-clear write clears bits written one
`timescale 1ns/10ps
`include "pcef_consts.vh"
module pcef_top #(
    parameter NGP = 2, // Number of general counters
    parameter CTR_W = 48, // Counter width
    parameter HAS_TRACE = 1, // Trace output capability present
    parameter HAS_ENCLAVE = 1 // Enclave capability present
) (
    input wire CLK_I,
    input wire RST_N_I,
    input wire CE_I,
    input wire MSR_RD_I,
    input wire MSR_WR_I,
    input wire [31:0] MSR_ADDR_I,
    input wire [63:0] MSR_WDATA_I,
    input wire [NGP-1:0] GP_EVT_OWN_I,
    input wire [NGP-1:0] GP_EVT_SIB_I,
    input wire [`PCEF_NFIX-1:0] FIX_EVT_OWN_I,
    input wire [`PCEF_NFIX-1:0] FIX_EVT_SIB_I,
    input wire OWN_USER_I,
    input wire SIB_USER_I,
    input wire TRACE_FULL_I,
    input wire ENCLAVE_OP_I,
    output reg [63:0] MSR_RDATA_O,
    output reg MSR_ACK_O,
    output reg MSR_FAULT_O,
    output reg OVF_INT_O,
    output reg BRANCH_CAPTURE_EN_O,
    output reg COUNTERS_FROZEN_O
);
    // Implemented global status bits
    localparam [63:0] GP_MASK = {{(64-NGP){1'b0}}, {NGP{1'b1}}};
    localparam [63:0] FIX_MASK = {{(64-`PCEF_NFIX){1'b0}}, {`PCEF_NFIX{1'b1}}} << `PCEF_FIX_BASE;
    localparam [63:0] CTRL_MASK = GP_MASK | FIX_MASK;
    localparam [63:0] FRZ_MASK = (64'h1 << `PCEF_ST_BRANCH_RECORD_FROZEN) | (64'h1 << `PCEF_ST_COUNTERS_FROZEN);
    localparam [63:0] TRACE_MASK = HAS_TRACE ? (64'h1 << `PCEF_ST_TRACE) : 64'h0;
    localparam [63:0] ENCL_MASK = HAS_ENCLAVE ? (64'h1 << `PCEF_ST_ENCL) : 64'h0;
    localparam [63:0] STAT_MASK = CTRL_MASK | FRZ_MASK | TRACE_MASK | ENCL_MASK;

    // Address match against a base plus an index
    function addr_hit;
        input [31:0] addr;
        input [31:0] base;
        input [31:0] idx;
        begin
            addr_hit = (addr == (base + idx));
        end
    endfunction

    // Widen a counter value to register width
    function [63:0] widen;
        input [CTR_W-1:0] val;
        begin
            widen = {{(64-CTR_W){1'b0}}, val};
        end
    endfunction

    reg [`PCEF_SEL_W-1:0] evtsel [0:NGP-1]; // Event select registers
    reg [`PCEF_FIXCTL_W-1:0] fixctl; // Fixed counter control blocks
    reg [63:0] gctrl; // Global control enables
    reg [`PCEF_DBG_W-1:0] dbgctl; // Debug control
    wire [63:0] status; // Global status
    wire [NGP*CTR_W-1:0] gp_cnt; // General counter values
    wire [`PCEF_NFIX*CTR_W-1:0] fix_cnt; // Fixed counter values
    wire [NGP-1:0] gp_ovf; // General counter overflow pulses
    wire [`PCEF_NFIX-1:0] fix_ovf; // Fixed counter overflow pulses
    wire [NGP-1:0] gp_en; // General count enables
    wire [`PCEF_NFIX-1:0] fix_en; // Fixed count enables
    wire [NGP-1:0] gp_int; // Overflow with interrupt requested
    wire [`PCEF_NFIX-1:0] fix_int; // Fixed overflow with interrupt requested
    wire [NGP-1:0] gp_wr; // General counter write strobes
    wire [`PCEF_NFIX-1:0] fix_wr; // Fixed counter write strobes
    wire counters_frozen; // Counters-frozen indicator
    wire cnt_ovf_int; // Counter overflow interrupt event
    wire any_en; // Some counter is enabled
    reg [63:0] set_vec; // Hardware status set requests
    wire [63:0] clr_vec; // Software status clear requests
    reg [63:0] next_rdata; // Read data for this access
    reg next_fault; // Access targets no register, or is a write to read-only status
    integer i; // Status set loop index
    integer j; // Read mux loop index
    integer k; // Register write loop index

    assign counters_frozen = status[`PCEF_ST_COUNTERS_FROZEN];

    // General counters and their enables
    genvar g;
    generate
        for (g = 0; g < NGP; g = g + 1) begin : gen_gp
            // Select enable, global enable, not frozen
            assign gp_en[g] = evtsel[g][`PCEF_SEL_EN] & gctrl[g] & ~counters_frozen;
            assign gp_int[g] = gp_ovf[g] & evtsel[g][`PCEF_SEL_INT];
            assign gp_wr[g] = MSR_WR_I & addr_hit(MSR_ADDR_I, `PCEF_ADDR_GPCTR0, g);
            pcef_counter #(
                .W(CTR_W)
            ) u_gp (
                .clk_i(CLK_I),
                .rst_n_i(RST_N_I),
                .ce_i(CE_I),
                .cnt_en_i(gp_en[g]),
                .usr_en_i(evtsel[g][`PCEF_SEL_USR]),
                .os_en_i(evtsel[g][`PCEF_SEL_OS]),
                .any_i(evtsel[g][`PCEF_SEL_ANY]),
                .own_evt_i(GP_EVT_OWN_I[g]),
                .sib_evt_i(GP_EVT_SIB_I[g]),
                .own_user_i(OWN_USER_I),
                .sib_user_i(SIB_USER_I),
                .wr_i(gp_wr[g]),
                .wdata_i(MSR_WDATA_I[CTR_W-1:0]),
                .count_o(gp_cnt[g*CTR_W +: CTR_W]),
                .ovf_o(gp_ovf[g])
            );
        end
        // Fixed counters, one 4-bit control block each
        for (g = 0; g < `PCEF_NFIX; g = g + 1) begin : gen_fix
            // Privilege enable, global enable, not frozen
            assign fix_en[g] = (fixctl[g*`PCEF_FIX_BLK + `PCEF_FIX_OS]
                | fixctl[g*`PCEF_FIX_BLK + `PCEF_FIX_USR])
                & gctrl[`PCEF_FIX_BASE + g] & ~counters_frozen;
            // Fourth bit of the block requests an interrupt
            assign fix_int[g] = fix_ovf[g] & fixctl[g*`PCEF_FIX_BLK + `PCEF_FIX_PMI];
            assign fix_wr[g] = MSR_WR_I & addr_hit(MSR_ADDR_I, `PCEF_ADDR_FIXCTR0, g);
            pcef_counter #(
                .W(CTR_W)
            ) u_fix (
                .clk_i(CLK_I),
                .rst_n_i(RST_N_I),
                .ce_i(CE_I),
                .cnt_en_i(fix_en[g]),
                .usr_en_i(fixctl[g*`PCEF_FIX_BLK + `PCEF_FIX_USR]),
                .os_en_i(fixctl[g*`PCEF_FIX_BLK + `PCEF_FIX_OS]),
                .any_i(fixctl[g*`PCEF_FIX_BLK + `PCEF_FIX_ANY]),
                .own_evt_i(FIX_EVT_OWN_I[g]),
                .sib_evt_i(FIX_EVT_SIB_I[g]),
                .own_user_i(OWN_USER_I),
                .sib_user_i(SIB_USER_I),
                .wr_i(fix_wr[g]),
                .wdata_i(MSR_WDATA_I[CTR_W-1:0]),
                .count_o(fix_cnt[g*CTR_W +: CTR_W]),
                .ovf_o(fix_ovf[g])
            );
        end
    endgenerate

    // Interrupting overflow of any counter
    assign cnt_ovf_int = (|gp_int) | (|fix_int);
    assign any_en = (|gp_en) | (|fix_en);

    // Hardware set requests into global status
    always @* begin
        set_vec = 64'h0;
        for (i = 0; i < NGP; i = i + 1) begin
            set_vec[i] = gp_ovf[i];
        end
        for (i = 0; i < `PCEF_NFIX; i = i + 1) begin
            set_vec[`PCEF_FIX_BASE + i] = fix_ovf[i];
        end
        // Freeze only through the status indicators; debug bits stay as written
        set_vec[`PCEF_ST_BRANCH_RECORD_FROZEN] = cnt_ovf_int & dbgctl[`PCEF_DBG_FRZ_LBR];
        set_vec[`PCEF_ST_COUNTERS_FROZEN] = cnt_ovf_int & dbgctl[`PCEF_DBG_FRZ_CTR];
        set_vec[`PCEF_ST_TRACE] = TRACE_FULL_I;
        set_vec[`PCEF_ST_ENCL] = ENCLAVE_OP_I & any_en;
    end

    // Only an overflow-clear write clears status
    assign clr_vec = (MSR_WR_I && MSR_ADDR_I == `PCEF_ADDR_GOVF) ?
        (MSR_WDATA_I & STAT_MASK) : 64'h0;

    // Sticky global status
    pcef_status #(
        .IMPL(STAT_MASK)
    ) u_status (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .set_i(set_vec),
        .clr_i(clr_vec),
        .status_o(status)
    );

    // Register read mux and access check
    always @* begin
        next_rdata = 64'h0;
        next_fault = 1'b1;
        for (j = 0; j < NGP; j = j + 1) begin
            if (addr_hit(MSR_ADDR_I, `PCEF_ADDR_EVTSEL0, j)) begin
                next_rdata = {{(64-`PCEF_SEL_W){1'b0}}, evtsel[j]};
                next_fault = 1'b0;
            end
            if (addr_hit(MSR_ADDR_I, `PCEF_ADDR_GPCTR0, j)) begin
                next_rdata = widen(gp_cnt[j*CTR_W +: CTR_W]);
                next_fault = 1'b0;
            end
        end
        for (j = 0; j < `PCEF_NFIX; j = j + 1) begin
            if (addr_hit(MSR_ADDR_I, `PCEF_ADDR_FIXCTR0, j)) begin
                next_rdata = widen(fix_cnt[j*CTR_W +: CTR_W]);
                next_fault = 1'b0;
            end
        end
        case (MSR_ADDR_I)
            `PCEF_ADDR_FIXCTL: begin
                next_rdata = {{(64-`PCEF_FIXCTL_W){1'b0}}, fixctl};
                next_fault = 1'b0;
            end
            `PCEF_ADDR_GSTAT: begin
                next_rdata = status;
                // Status is read-only; a write faults and changes nothing
                next_fault = MSR_WR_I;
            end
            `PCEF_ADDR_GCTRL: begin
                next_rdata = gctrl;
                next_fault = 1'b0;
            end
            `PCEF_ADDR_GOVF: begin
                next_rdata = 64'h0;
                next_fault = 1'b0;
            end
            `PCEF_ADDR_DBGCTL: begin
                next_rdata = {{(64-`PCEF_DBG_W){1'b0}}, dbgctl};
                next_fault = 1'b0;
            end
            default: begin
                next_rdata = next_rdata;
            end
        endcase
    end

    // Writable control registers
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            for (k = 0; k < NGP; k = k + 1) begin
                evtsel[k] <= {`PCEF_SEL_W{1'b0}};
            end
            fixctl <= {`PCEF_FIXCTL_W{1'b0}};
            gctrl <= 64'h0;
            dbgctl <= {`PCEF_DBG_W{1'b0}};
        end else if (CE_I && MSR_WR_I) begin
            for (k = 0; k < NGP; k = k + 1) begin
                if (addr_hit(MSR_ADDR_I, `PCEF_ADDR_EVTSEL0, k)) begin
                    evtsel[k] <= MSR_WDATA_I[`PCEF_SEL_W-1:0];
                end
            end
            // Fixed control: one 4-bit block per counter
            if (MSR_ADDR_I == `PCEF_ADDR_FIXCTL) begin
                fixctl <= MSR_WDATA_I[`PCEF_FIXCTL_W-1:0];
            end
            // Global control takes only implemented enables
            if (MSR_ADDR_I == `PCEF_ADDR_GCTRL) begin
                gctrl <= MSR_WDATA_I & CTRL_MASK;
            end
            if (MSR_ADDR_I == `PCEF_ADDR_DBGCTL) begin
                dbgctl <= MSR_WDATA_I[`PCEF_DBG_W-1:0];
            end
        end
    end

    // Access answer and registered outputs
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            MSR_RDATA_O <= 64'h0;
            MSR_ACK_O <= 1'b0;
            MSR_FAULT_O <= 1'b0;
            OVF_INT_O <= 1'b0;
            BRANCH_CAPTURE_EN_O <= 1'b0;
            COUNTERS_FROZEN_O <= 1'b0;
        end else if (CE_I) begin
            MSR_ACK_O <= MSR_RD_I | MSR_WR_I;
            // Faulting access returns zero data
            if (MSR_RD_I | MSR_WR_I) begin
                MSR_RDATA_O <= (next_fault | MSR_WR_I) ? 64'h0 : next_rdata;
                MSR_FAULT_O <= next_fault;
            end else begin
                MSR_RDATA_O <= 64'h0;
                MSR_FAULT_O <= 1'b0;
            end
            // Counter or trace buffer interrupt, one cycle pulse
            OVF_INT_O <= cnt_ovf_int | (TRACE_FULL_I & (HAS_TRACE != 0));
            // Capture only while enabled and not frozen
            BRANCH_CAPTURE_EN_O <= dbgctl[`PCEF_DBG_LBR] & ~status[`PCEF_ST_BRANCH_RECORD_FROZEN];
            COUNTERS_FROZEN_O <= counters_frozen;
        end
    end
endmodule // pcef_top

// File: testbench/pcef_top_chk.sv
// Port-level checker of the counter control block
`timescale 1ns/10ps
module pcef_top_chk #(
    parameter HAS_TRACE = 1 // Trace capability present
) (
    input wire CLK_I,
    input wire RST_N_I,
    input wire CE_I,
    input wire MSR_RD_I,
    input wire MSR_WR_I,
    input wire [31:0] MSR_ADDR_I,
    input wire [63:0] MSR_WDATA_I,
    input wire TRACE_FULL_I,
    input wire [63:0] MSR_RDATA_O,
    input wire MSR_ACK_O,
    input wire MSR_FAULT_O,
    input wire OVF_INT_O,
    input wire COUNTERS_FROZEN_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Access taken at this edge
    wire acc = CE_I && (MSR_RD_I || MSR_WR_I);
    // Clear write hitting the counters-frozen bit
    wire clr59 = CE_I && MSR_WR_I && MSR_ADDR_I == 32'h0000_0383 && MSR_WDATA_I[59];
    // Read of one address taken
    sequence read_at(a);
        CE_I && MSR_RD_I && MSR_ADDR_I == a;
    endsequence
    // Answer without fault
    sequence clean_ack;
        MSR_ACK_O && !MSR_FAULT_O;
    endsequence
    ack_resp_a: assert property (acc |=> MSR_ACK_O)
        else $error("access not answered");
    ack_idle_a: assert property (CE_I && !MSR_RD_I && !MSR_WR_I |=> !MSR_ACK_O)
        else $error("answer without access");
    idle_data_zero_a: assert property (!MSR_ACK_O |-> MSR_RDATA_O == 64'h0)
        else $error("read data outside answer");
    status_wr_fault_a: assert property (
        CE_I && MSR_WR_I && MSR_ADDR_I == 32'h0000_0381 |=> MSR_ACK_O && MSR_FAULT_O)
        else $error("status write not refused");
    clear_reads_zero_a: assert property (
        read_at(32'h0000_0383) |=> clean_ack ##0 MSR_RDATA_O == 64'h0)
        else $error("clear register reads nonzero");
    unmapped_fault_a: assert property (
        read_at(32'h0000_0385) |=> MSR_FAULT_O && MSR_RDATA_O == 64'h0)
        else $error("unmapped read not refused");
    select_map_a: assert property (read_at(32'h0000_0187) |=> clean_ack)
        else $error("second event select unmapped");
    fixed_map_a: assert property (read_at(32'h0000_030b) |=> clean_ack)
        else $error("third fixed counter unmapped");
    frozen_hold_a: assert property (
        (CE_I && !clr59) ##1 (COUNTERS_FROZEN_O && CE_I && !clr59) |=> COUNTERS_FROZEN_O)
        else $error("frozen dropped without clear");
    trace_int_a: assert property (
        HAS_TRACE != 0 && CE_I && TRACE_FULL_I |-> ##[1:2] OVF_INT_O)
        else $error("trace full gave no interrupt");
endmodule // pcef_top_chk

bind pcef_top pcef_top_chk #(.HAS_TRACE(HAS_TRACE)) i_pcef_top_chk (
    .CLK_I(CLK_I),
    .RST_N_I(RST_N_I),
    .CE_I(CE_I),
    .MSR_RD_I(MSR_RD_I),
    .MSR_WR_I(MSR_WR_I),
    .MSR_ADDR_I(MSR_ADDR_I),
    .MSR_WDATA_I(MSR_WDATA_I),
    .TRACE_FULL_I(TRACE_FULL_I),
    .MSR_RDATA_O(MSR_RDATA_O),
    .MSR_ACK_O(MSR_ACK_O),
    .MSR_FAULT_O(MSR_FAULT_O),
    .OVF_INT_O(OVF_INT_O),
    .COUNTERS_FROZEN_O(COUNTERS_FROZEN_O)
);

// File: testbench/tb.sv
// Self-checking bench of the counter control block
`timescale 1ns/10ps
module tb;
    reg CLK_I = 1'b0;
    reg RST_N_I = 1'b0;
    reg CE_I = 1'b1;
    reg MSR_RD_I = 1'b0;
    reg MSR_WR_I = 1'b0;
    reg [31:0] MSR_ADDR_I = 32'h0;
    reg [63:0] MSR_WDATA_I = 64'h0;
    reg [1:0] GP_EVT_OWN_I = 2'h0;
    reg [1:0] GP_EVT_SIB_I = 2'h0;
    reg [2:0] FIX_EVT_OWN_I = 3'h0;
    reg [2:0] FIX_EVT_SIB_I = 3'h0;
    reg OWN_USER_I = 1'b0;
    reg SIB_USER_I = 1'b0;
    reg TRACE_FULL_I = 1'b0;
    reg ENCLAVE_OP_I = 1'b0;
    wire [63:0] MSR_RDATA_O;
    wire MSR_ACK_O;
    wire MSR_FAULT_O;
    wire OVF_INT_O;
    wire BRANCH_CAPTURE_EN_O;
    wire COUNTERS_FROZEN_O;
    integer n_errors = 0; // Mismatches
    integer comparisons = 0; // Checks made
    integer model; // Expected count
    integer k; // Scenario index
    reg [63:0] d; // Random data
    reg [63:0] m; // Readback mask
    reg [31:0] a; // Register address
    pcef_top #(.NGP(2), .CTR_W(48)) i_pcef_top (
        .CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
        .MSR_RD_I(MSR_RD_I), .MSR_WR_I(MSR_WR_I), .MSR_ADDR_I(MSR_ADDR_I),
        .MSR_WDATA_I(MSR_WDATA_I), .GP_EVT_OWN_I(GP_EVT_OWN_I), .GP_EVT_SIB_I(GP_EVT_SIB_I),
        .FIX_EVT_OWN_I(FIX_EVT_OWN_I), .FIX_EVT_SIB_I(FIX_EVT_SIB_I),
        .OWN_USER_I(OWN_USER_I), .SIB_USER_I(SIB_USER_I), .TRACE_FULL_I(TRACE_FULL_I),
        .ENCLAVE_OP_I(ENCLAVE_OP_I), .MSR_RDATA_O(MSR_RDATA_O), .MSR_ACK_O(MSR_ACK_O),
        .MSR_FAULT_O(MSR_FAULT_O), .OVF_INT_O(OVF_INT_O),
        .BRANCH_CAPTURE_EN_O(BRANCH_CAPTURE_EN_O), .COUNTERS_FROZEN_O(COUNTERS_FROZEN_O)
    );
    // Clock of 40 ns
    always #20 CLK_I = ~CLK_I;
    // Compare of a wide value
    task cmp64(input [63:0] got, input [63:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Compare of a flag
    task cmp1(input got, input exp);
        begin
            cmp64({63'h0, got}, {63'h0, exp});
        end
    endtask
    // One register access, answer checked a cycle later
    task acc(input wr, input [31:0] ad, input [63:0] wd, input [63:0] exp, input flt);
        begin
            @(posedge CLK_I);
            MSR_RD_I <= !wr;
            MSR_WR_I <= wr;
            MSR_ADDR_I <= ad;
            MSR_WDATA_I <= wd;
            @(posedge CLK_I);
            MSR_RD_I <= 1'b0;
            MSR_WR_I <= 1'b0;
            #1;
            cmp1(MSR_ACK_O, 1'b1);
            cmp1(MSR_FAULT_O, flt);
            if (!wr) cmp64(MSR_RDATA_O, exp);
        end
    endtask
    // Random events; c is gate, any, kernel_user_select of the watched counter
    task drive(input integer n, input integer fx, input integer ix, input [3:0] c);
        integer i;
        reg [11:0] r;
        reg o;
        reg s;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge CLK_I);
                r = $urandom;
                {SIB_USER_I, OWN_USER_I, FIX_EVT_SIB_I, FIX_EVT_OWN_I} <= r[11:4];
                {GP_EVT_SIB_I, GP_EVT_OWN_I} <= r[3:0];
                o = fx ? r[4 + ix] : r[ix];
                s = fx ? r[7 + ix] : r[2 + ix];
                if (c[3]) model = model + (o && (c[0] && r[10] || c[1] && !r[10]))
                    + (s && c[2] && (c[0] && r[11] || c[1] && !r[11]));
            end
            @(posedge CLK_I);
            {FIX_EVT_SIB_I, FIX_EVT_OWN_I, GP_EVT_SIB_I, GP_EVT_OWN_I} <= 10'h0;
        end
    endtask
    // Wrap one counter armed for interrupt and check status and freeze outputs
    task ovf(input integer fx, input integer ix, input [63:0] dbg);
        integer i;
        begin
            acc(1, 32'h384, dbg, 0, 0);
            if (fx) acc(1, 32'h380, 64'hb << (4 * ix), 0, 0);
            else acc(1, 32'h186 + ix, 64'h53_0000, 0, 0);
            acc(1, fx ? 32'h309 + ix : 32'hc1 + ix, 64'hffff_ffff_ffff, 0, 0);
            // Global control goes last, after the counter is set up
            acc(1, 32'h382, 64'h7_0000_0003, 0, 0);
            @(posedge CLK_I);
            OWN_USER_I <= 1'b1;
            if (fx) FIX_EVT_OWN_I <= 3'h1 << ix;
            else GP_EVT_OWN_I <= 2'h1 << ix;
            @(posedge CLK_I);
            FIX_EVT_OWN_I <= 3'h0;
            GP_EVT_OWN_I <= 2'h0;
            #1;
            for (i = 0; i < 4 && OVF_INT_O !== 1'b1; i = i + 1) begin
                @(posedge CLK_I);
                #1;
            end
            cmp1(OVF_INT_O, 1'b1);
            @(posedge CLK_I);
            #1;
            cmp1(OVF_INT_O, 1'b0);
            d = (64'h1 << (fx ? 32 + ix : ix)) | ({63'h0, dbg[11]} << 58);
            acc(0, 32'h381, 0, d | ({63'h0, dbg[12]} << 59), 0);
            cmp1(COUNTERS_FROZEN_O, dbg[12]);
            cmp1(BRANCH_CAPTURE_EN_O, dbg[0] & !dbg[11]);
        end
    endtask
    // Counts, verdict and end of run
    task wrap_up;
        begin
            $display("comparisons %0d errors %0d", comparisons, n_errors);
            if (n_errors == 0 && comparisons > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        #400000;
        n_errors = n_errors + 1;
        wrap_up;
    end
    // Main sequence
    initial begin
        void'($urandom(78));
        repeat (4) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        acc(0, 32'h381, 0, 0, 0);
        acc(0, 32'h30b, 0, 0, 0);
        acc(1, 32'h381, 64'h0800_0000_0000_0003, 0, 1);
        acc(0, 32'h381, 0, 0, 0);
        acc(0, 32'h385, 0, 0, 1);
        acc(0, 32'h383, 0, 0, 0);
        // Write and read back each control register with random data
        for (k = 0; k < 5; k = k + 1) begin
            a = (k < 2) ? 32'h186 + k : 32'h37c + 2 * k;
            m = (k < 2) ? 64'hffff_ffff : (k == 2) ? 64'hfff : (k == 3) ? 64'h7_0000_0003
                : 64'hffff;
            d = {$urandom, $urandom};
            acc(1, a, d, 0, 0);
            acc(0, a, 0, d & m, 0);
        end
        acc(1, 32'h384, 64'h0, 0, 0);
        // Core-wide, privilege and enable cases on general and fixed counters
        for (k = 0; k < 16; k = k + 1) begin
            if (k[3]) acc(1, 32'h380, {56'h0, 1'b0, k[0], k[2], !k[2], 4'h0}, 0, 0);
            else acc(1, 32'h186, {41'h0, 1'b1, k[0], 3'h0, !k[2], k[2], 16'h0}, 0, 0);
            acc(1, 32'h382, k[1] ? (k[3] ? 64'h2_0000_0000 : 64'h1) : 64'h0, 0, 0);
            acc(1, k[3] ? 32'h30a : 32'hc1, 0, 0, 0);
            model = 0;
            drive(12, k[3], k[3], {k[1], k[0], !k[2], k[2]});
            acc(0, k[3] ? 32'h30a : 32'hc1, 0, model, 0);
        end
        // Freeze of both, then clear and resume
        ovf(0, 0, 64'h1801);
        drive(10, 0, 0, 4'h3);
        acc(0, 32'hc1, 0, 0, 0);
        acc(1, 32'h383, 64'h0c00_0000_0000_0001, 0, 0);
        acc(0, 32'h381, 0, 0, 0);
        cmp1(COUNTERS_FROZEN_O, 1'b0);
        cmp1(BRANCH_CAPTURE_EN_O, 1'b1);
        model = 0;
        drive(10, 0, 0, 4'hb);
        acc(0, 32'hc1, 0, model, 0);
        // Fixed overflow without freeze, then branch freeze alone
        ovf(1, 2, 64'h1);
        acc(1, 32'h383, 64'h4_0000_0000, 0, 0);
        ovf(0, 1, 64'h801);
        acc(1, 32'h383, 64'h0400_0000_0000_0002, 0, 0);
        acc(0, 32'h381, 0, 0, 0);
        cmp1(BRANCH_CAPTURE_EN_O, 1'b1);
        // Trace buffer full and enclave activity
        @(posedge CLK_I);
        TRACE_FULL_I <= 1'b1;
        ENCLAVE_OP_I <= 1'b1;
        @(posedge CLK_I);
        TRACE_FULL_I <= 1'b0;
        ENCLAVE_OP_I <= 1'b0;
        acc(0, 32'h381, 0, 64'h1080_0000_0000_0000, 0);
        acc(1, 32'h383, 64'h1080_0000_0000_0000, 0, 0);
        acc(0, 32'h381, 0, 0, 0);
        // Clock enable low: a trace full pulse must leave no mark
        @(posedge CLK_I);
        CE_I <= 1'b0;
        TRACE_FULL_I <= 1'b1;
        repeat (3) @(posedge CLK_I);
        TRACE_FULL_I <= 1'b0;
        CE_I <= 1'b1;
        acc(0, 32'h381, 0, 0, 0);
        cmp1(OVF_INT_O, 1'b0);
        wrap_up;
    end
endmodule // tb
